// *** hw/pid_sup_pkg.sv ***
// constants and register map for the regulator supervision block
package pid_sup_pkg;
    localparam int DATA_W = 16;
    localparam int CLOCK_HZ = 50000000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = (CLOCK_HZ / 1000000) * TICK_US;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ILIM = 8'h04;
    localparam logic [7:0] ADDR_OLIM = 8'h08;
    localparam logic [7:0] ADDR_OFFS = 8'h0C;
    localparam logic [7:0] ADDR_FILT = 8'h10;
    localparam logic [7:0] ADDR_GAIN = 8'h14;
    localparam logic [7:0] ADDR_RAMP = 8'h18;
    localparam logic [7:0] ADDR_LLVL = 8'h1C;
    localparam logic [7:0] ADDR_LTIM = 8'h20;
    localparam logic [7:0] ADDR_SLVL = 8'h24;
    localparam logic [7:0] ADDR_STIM = 8'h28;
    localparam logic [7:0] ADDR_STAT = 8'h2C;
    localparam logic [7:0] ADDR_MASK = 8'h30;
    localparam logic [7:0] ADDR_OUT = 8'h34;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_POL_BIT = 3;
    localparam int CTRL_REVSEL_BIT = 4;
    localparam int CTRL_REVPROH_BIT = 5;
    localparam int CTRL_LMODE_LSB = 6;
    localparam int ST_ALARM_BIT = 0;
    localparam int ST_FAULT_BIT = 1;
    localparam int ST_SLEEP_BIT = 2;
    localparam int ST_WAKE_BIT = 3;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam logic [15:0] FULL_SCALE = 16'h2710;
    localparam logic [15:0] LIMIT_RESET = 16'h2710;
    localparam logic [3:0] GAIN_ONE = 4'h8;
    localparam int OFFSET_STEP = 10;
    localparam logic [15:0] OFFSET_MAX = 16'h03E8;
    localparam logic [1:0] LOSS_OFF = 2'h0;
    localparam logic [1:0] LOSS_ALARM = 2'h1;
    localparam logic [1:0] LOSS_FAULT = 2'h2;
endpackage

// *** hw/pid_regulator_supervision.sv ***
// regulator post-processing, target ramp, loss detection and sleep supervision
//
// Functional notes
// - integral accumulator clamped to integral limit
// - combined result clamped to output limit
// - offset added in tenth-percent steps
// - first-order low-pass filter on output
// - polarity select negates regulator output
// - gain applied before adding as compensation
// - negative output floored unless reverse allowed
// - target ramped at dedicated ramp rate
// - soft-start input bypasses target ramp while run command is set
// - speed ramps applied after regulator output
// - loss mode one raises alarm, keeps running
// - loss mode two faults and stops
// - sleep when target low for delay
// - wake when target high for delay
// - sleep disabled while regulator disabled
// - four modes: reference or compensation, D source
// - disable input turns regulator off
// - hold input freezes integral accumulator
`timescale 1ns/1ns
`default_nettype none
module pid_regulator_supervision
    import pid_sup_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic run_cmd,
    input wire logic disable_in,
    input wire logic hold_in,
    input wire logic soft_bypass_in,
    input wire logic signed [15:0] target_in,
    input wire logic signed [15:0] feedback_in,
    input wire logic signed [15:0] freq_ref_in,
    input wire logic signed [15:0] p_term,
    input wire logic signed [15:0] i_increment,
    input wire logic signed [15:0] d_error_term,
    input wire logic signed [15:0] d_feedback_term,
    output logic signed [15:0] ramp_target,
    output logic signed [15:0] speed_ref,
    output logic reverse_cmd,
    output logic run_out,
    output logic feedback_lost_alarm,
    output logic fault_out,
    output logic irq
);
    logic [31:0] ctrl_reg;
    logic [15:0] integral_limit, output_limit, output_filter_time, target_ramp_time;
    logic signed [15:0] output_offset;
    logic [3:0] output_gain;
    logic [15:0] loss_detect_level, loss_detect_time, sleep_level, sleep_time;
    logic [3:0] stat_reg, mask_reg, ev;
    logic tick;
    logic [15:0] tick_cnt;
    logic signed [15:0] integ_reg;
    logic signed [31:0] filt_reg;
    logic [15:0] loss_cnt, sleep_cnt, ramp_cnt;
    logic sleeping_reg, fault_reg, alarm_reg;
    logic [2:0] mode;
    logic reg_en;
    logic [1:0] loss_detect_mode;
    logic wr, rd;

    function automatic logic signed [15:0] clamp(input logic signed [17:0] v,
                                                 input logic [15:0] lim);
        logic signed [17:0] l;
        l = $signed({2'b00, lim});
        if (v > l)
            clamp = l[15:0];
        else if (v < -l)
            clamp = -lim;
        else
            clamp = v[15:0];
    endfunction

    assign mode = ctrl_reg[CTRL_MODE_LSB +: 3];
    assign loss_detect_mode = ctrl_reg[CTRL_LMODE_LSB +: 2];
    assign reg_en = (mode >= 3'd1) && (mode <= 3'd4) && !disable_in;
    assign wr = psel && penable && pwrite;
    assign rd = psel && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // register writes
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= CTRL_RESET;
            integral_limit <= LIMIT_RESET;
            output_limit <= LIMIT_RESET;
            output_offset <= '0;
            output_filter_time <= '0;
            output_gain <= GAIN_ONE;
            target_ramp_time <= '0;
            loss_detect_level <= '0;
            loss_detect_time <= '0;
            sleep_level <= '0;
            sleep_time <= '0;
            mask_reg <= '0;
        end else if (clk_en && wr) begin
            unique case (paddr)
                ADDR_CTRL: ctrl_reg <= pwdata;
                ADDR_ILIM: integral_limit <= pwdata[15:0];
                ADDR_OLIM: output_limit <= pwdata[15:0];
                ADDR_OFFS: output_offset <= pwdata[15:0];
                ADDR_FILT: output_filter_time <= pwdata[15:0];
                ADDR_GAIN: output_gain <= pwdata[3:0];
                ADDR_RAMP: target_ramp_time <= pwdata[15:0];
                ADDR_LLVL: loss_detect_level <= pwdata[15:0];
                ADDR_LTIM: loss_detect_time <= pwdata[15:0];
                ADDR_SLVL: sleep_level <= pwdata[15:0];
                ADDR_STIM: sleep_time <= pwdata[15:0];
                ADDR_MASK: mask_reg <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    // read data from flip-flops
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            prdata <= '0;
        else if (clk_en && rd && !penable) begin
            unique case (paddr)
                ADDR_CTRL: prdata <= ctrl_reg;
                ADDR_ILIM: prdata <= {16'h0000, integral_limit};
                ADDR_OLIM: prdata <= {16'h0000, output_limit};
                ADDR_OFFS: prdata <= {16'h0000, output_offset};
                ADDR_FILT: prdata <= {16'h0000, output_filter_time};
                ADDR_GAIN: prdata <= {28'h0000000, output_gain};
                ADDR_RAMP: prdata <= {16'h0000, target_ramp_time};
                ADDR_LLVL: prdata <= {16'h0000, loss_detect_level};
                ADDR_LTIM: prdata <= {16'h0000, loss_detect_time};
                ADDR_SLVL: prdata <= {16'h0000, sleep_level};
                ADDR_STIM: prdata <= {16'h0000, sleep_time};
                ADDR_STAT: prdata <= {28'h0000000, stat_reg};
                ADDR_MASK: prdata <= {28'h0000000, mask_reg};
                ADDR_OUT: prdata <= {16'h0000, speed_ref};
                default: prdata <= '0;
            endcase
        end
    end

    // millisecond time base
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            tick_cnt <= '0;
        else if (clk_en)
            tick_cnt <= (tick_cnt == 16'(TICK_DIV - 1)) ? 16'h0000 : tick_cnt + 16'h0001;
    end
    assign tick = clk_en && (tick_cnt == 16'(TICK_DIV - 1));

    // target soft-start ramp: one count step every ramp time + 1 ticks
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ramp_target <= '0;
            ramp_cnt <= '0;
        end else if (clk_en) begin
            if ((soft_bypass_in && run_cmd) || target_ramp_time == 16'h0000) begin
                ramp_target <= target_in;
                ramp_cnt <= '0;
            end else if (tick) begin
                if (ramp_cnt >= target_ramp_time) begin
                    ramp_cnt <= '0;
                    if (ramp_target < target_in)
                        ramp_target <= ramp_target + 16'sh0001;
                    else if (ramp_target > target_in)
                        ramp_target <= ramp_target - 16'sh0001;
                end else
                    ramp_cnt <= ramp_cnt + 16'h0001;
            end
        end
    end

    // integral accumulator
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            integ_reg <= '0;
        else if (clk_en) begin
            if (!reg_en || !run_out)
                integ_reg <= '0;
            else if (!hold_in)
                integ_reg <= clamp(18'(integ_reg) + 18'(i_increment), integral_limit);
        end
    end

    logic signed [15:0] d_term, pid_sum, offs_cnt, lim_out, inv_out, filt_out, gained, final_out;
    logic signed [19:0] gain_prod;
    logic signed [17:0] ref_sum;
    always_comb begin
        d_term = (mode == 3'd2 || mode == 3'd4) ? d_feedback_term : d_error_term;
        pid_sum = clamp(18'(p_term) + 18'(integ_reg) + 18'(d_term), FULL_SCALE);
        offs_cnt = clamp(18'(output_offset), OFFSET_MAX);
        lim_out = clamp(18'(pid_sum) + 18'(offs_cnt) * 18'(OFFSET_STEP),
                        output_limit);
        inv_out = ctrl_reg[CTRL_POL_BIT] ? -lim_out : lim_out;
    end

    // first-order filter, fraction 1/(time+1) per tick
    assign filt_out = filt_reg[31:16];
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            filt_reg <= '0;
        else if (clk_en) begin
            if (output_filter_time == 16'h0000)
                filt_reg <= {inv_out, 16'h0000};
            else if (tick)
                filt_reg <= filt_reg + (($signed({inv_out, 16'h0000}) - filt_reg) /
                            $signed({15'h0000, {1'b0, output_filter_time} + 17'h00001}));
        end
    end

    always_comb begin
        gain_prod = 20'(filt_out) * $signed({16'h0000, output_gain});
        gained = clamp(18'(gain_prod >>> 3), FULL_SCALE);
        if (!reg_en)
            ref_sum = 18'(freq_ref_in);
        else if (mode >= 3'd3)
            ref_sum = 18'(freq_ref_in) + 18'(gained);
        else
            ref_sum = 18'(gained);
        final_out = clamp(ref_sum, FULL_SCALE);
        if (final_out < 0 && (!ctrl_reg[CTRL_REVSEL_BIT] || ctrl_reg[CTRL_REVPROH_BIT]))
            final_out = '0;
    end

    // outputs feed the downstream speed ramps
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            speed_ref <= '0;
            reverse_cmd <= 1'b0;
        end else if (clk_en) begin
            speed_ref <= (final_out < 0) ? -final_out : final_out;
            reverse_cmd <= final_out < 0;
        end
    end

    // feedback loss detection
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            loss_cnt <= '0;
            alarm_reg <= 1'b0;
            fault_reg <= 1'b0;
        end else if (clk_en) begin
            if (!reg_en || loss_detect_mode == LOSS_OFF ||
                feedback_in >= $signed(loss_detect_level)) begin
                loss_cnt <= '0;
                alarm_reg <= 1'b0;
            end else if (loss_cnt >= loss_detect_time) begin
                if (loss_detect_mode == LOSS_ALARM)
                    alarm_reg <= 1'b1;
                else if (loss_detect_mode == LOSS_FAULT)
                    fault_reg <= 1'b1;
            end else if (tick)
                loss_cnt <= loss_cnt + 16'h0001;
            if (fault_reg && !run_cmd)
                fault_reg <= 1'b0;
            // alarm only stands while alarm mode is selected
            if (loss_detect_mode != LOSS_ALARM)
                alarm_reg <= 1'b0;
        end
    end
    assign feedback_lost_alarm = alarm_reg;
    assign fault_out = fault_reg;

    // sleep / wake supervision
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sleep_cnt <= '0;
            sleeping_reg <= 1'b0;
        end else if (clk_en) begin
            if (!reg_en) begin
                sleep_cnt <= '0;
                sleeping_reg <= 1'b0;
            end else if ((target_in < $signed(sleep_level)) != sleeping_reg) begin
                if (sleep_cnt >= sleep_time) begin
                    sleep_cnt <= '0;
                    sleeping_reg <= !sleeping_reg;
                end else if (tick)
                    sleep_cnt <= sleep_cnt + 16'h0001;
            end else
                sleep_cnt <= '0;
        end
    end
    assign run_out = run_cmd && !sleeping_reg && !fault_reg;

    // sticky status, set wins over clear
    logic alarm_d, sleep_d;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            alarm_d <= 1'b0;
            sleep_d <= 1'b0;
        end else if (clk_en) begin
            alarm_d <= alarm_reg | fault_reg;
            sleep_d <= sleeping_reg;
        end
    end
    assign ev = {sleep_d & !sleeping_reg, !sleep_d & sleeping_reg, fault_reg,
                 !alarm_d & alarm_reg};
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            stat_reg <= '0;
        else if (clk_en) begin
            if (wr && paddr == ADDR_STAT)
                stat_reg <= (stat_reg & ~pwdata[3:0]) | ev;
            else
                stat_reg <= stat_reg | ev;
        end
    end
    assign irq = |(stat_reg & mask_reg);

    a_integ_bound: assert property (@(posedge clock) disable iff (!arst_n)
        integ_reg <= $signed(integral_limit) && integ_reg >= -$signed(integral_limit)
        || $changed(integral_limit))
        else $error("integral beyond limit");
    a_floor_zero: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && ctrl_reg[CTRL_REVPROH_BIT] |=> !reverse_cmd)
        else $error("reverse while prohibited");
    a_revsel_gate: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && !ctrl_reg[CTRL_REVSEL_BIT] |=> !reverse_cmd)
        else $error("reverse without reverse select");
    a_hold_freeze: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && hold_in && reg_en && run_out |=> $stable(integ_reg))
        else $error("integral moved during hold");
    a_fault_stop: assert property (@(posedge clock) disable iff (!arst_n)
        fault_reg |-> !run_out)
        else $error("running with fault");
    a_fault_latch: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && run_cmd && reg_en && loss_detect_mode == LOSS_FAULT &&
        feedback_in < $signed(loss_detect_level) && loss_cnt >= loss_detect_time |=> fault_reg)
        else $error("fault not latched");
    a_loss_reset: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && feedback_in >= $signed(loss_detect_level) |=> loss_cnt == 16'h0000)
        else $error("loss timer not restarted");
    a_sleep_off: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && !reg_en |=> !sleeping_reg)
        else $error("sleep while regulator off");
    a_sleep_enter: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && reg_en && !sleeping_reg && target_in < $signed(sleep_level) &&
        sleep_cnt >= sleep_time |=> sleeping_reg)
        else $error("sleep not entered");
    a_wake_exit: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && reg_en && sleeping_reg && target_in >= $signed(sleep_level) &&
        sleep_cnt >= sleep_time |=> !sleeping_reg)
        else $error("wake not taken");
    a_bypass_ramp: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && soft_bypass_in && run_cmd |=> ramp_target == $past(target_in))
        else $error("ramp not bypassed");
    a_ramp_step: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && !(soft_bypass_in && run_cmd) && target_ramp_time != 16'h0000 |=>
        ramp_target == $past(ramp_target) || ramp_target == $past(ramp_target) + 16'sh0001
        || ramp_target == $past(ramp_target) - 16'sh0001)
        else $error("target ramp jumped");
    a_alarm_mode: assert property (@(posedge clock) disable iff (!arst_n)
        alarm_reg |-> loss_detect_mode == LOSS_ALARM || $changed(loss_detect_mode))
        else $error("alarm outside alarm mode");
    a_enable_freeze: assert property (@(posedge clock) disable iff (!arst_n)
        !clk_en |=> $stable(speed_ref) && $stable(integ_reg) && $stable(stat_reg))
        else $error("state moved while clock enable low");
    c_fault: cover property (@(posedge clock) disable iff (!arst_n) $rose(fault_reg));
    c_alarm: cover property (@(posedge clock) disable iff (!arst_n) $rose(alarm_reg));
    c_sleep: cover property (@(posedge clock) disable iff (!arst_n) $fell(sleeping_reg));
    c_sleep_entry: cover property (@(posedge clock) disable iff (!arst_n) $rose(sleeping_reg));
    c_reverse: cover property (@(posedge clock) disable iff (!arst_n) $rose(reverse_cmd));
endmodule
`default_nettype wire

// *** testbench/drive_model.sv ***
// drive reference and ramp generator model beside the regulator
`timescale 1ns/1ns
`default_nettype none
module drive_model
    import pid_sup_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic signed [15:0] freq_set,
    input wire logic signed [15:0] speed_ref,
    input wire logic run_out,
    output logic signed [15:0] freq_ref,
    output logic signed [15:0] motor_freq
);
    assign freq_ref = freq_set;
    // normal speed ramp follows the regulator output, one count a cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            motor_freq <= 16'sh0000;
        end else if (!run_out) begin
            motor_freq <= 16'sh0000;
        end else if (motor_freq < speed_ref) begin
            motor_freq <= motor_freq + 16'sh0001;
        end else if (motor_freq > speed_ref) begin
            motor_freq <= motor_freq - 16'sh0001;
        end
    end
endmodule
`default_nettype wire

// *** testbench/pid_regulator_supervision_tb.sv ***
// self-checking bench for the regulator supervision block
`timescale 1ns/1ns
`default_nettype none
module pid_regulator_supervision_tb;
    import pid_sup_pkg::*;
    logic clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, q;
    logic pready, pslverr, reverse_cmd, run_out, alarm, fault_out, irq;
    logic run_cmd = 1'b0, disable_in = 1'b0, hold_in = 1'b0, soft_bypass_in = 1'b0;
    logic clk_en = 1'b1;
    logic signed [15:0] target_in = 16'sh0000, feedback_in = 16'sh03E8, p_term = 16'sh0000;
    logic signed [15:0] i_increment = 16'sh0000, freq_set = 16'sh0000;
    logic signed [15:0] d_err = 16'sh0000, d_fb = 16'sh0000;
    logic signed [15:0] freq_ref_in, ramp_target, speed_ref, motor_freq;
    logic [7:0] ca [11] = '{ADDR_ILIM, ADDR_OLIM, ADDR_OFFS, ADDR_FILT, ADDR_GAIN, ADDR_RAMP,
        ADDR_LLVL, ADDR_LTIM, ADDR_SLVL, ADDR_STIM, ADDR_MASK};
    logic [31:0] cd [11] = '{32'h000001F4, 32'h00002710, 32'h0, 32'h0, 32'h00000008,
        32'h00000002, 32'h00000064, 32'h00000005, 32'h0, 32'h00000005, 32'h0};
    int n_mismatch = 0, cmp_count = 0, cyc = 0;

    always #10 clock = ~clock;

    pid_regulator_supervision #(.TICK_DIV(4)) u_dut (
        .clock(clock), .arst_n(arst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .run_cmd(run_cmd), .disable_in(disable_in), .hold_in(hold_in),
        .soft_bypass_in(soft_bypass_in), .target_in(target_in), .feedback_in(feedback_in),
        .freq_ref_in(freq_ref_in), .p_term(p_term), .i_increment(i_increment),
        .d_error_term(d_err), .d_feedback_term(d_fb), .ramp_target(ramp_target),
        .speed_ref(speed_ref), .reverse_cmd(reverse_cmd), .run_out(run_out),
        .feedback_lost_alarm(alarm), .fault_out(fault_out), .irq(irq));

    drive_model u_drv (.clock(clock), .arst_n(arst_n), .freq_set(freq_set),
        .speed_ref(speed_ref), .run_out(run_out), .freq_ref(freq_ref_in),
        .motor_freq(motor_freq));

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc > 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic done(input string t);
        $display("test %s finished", t);
    endtask

    initial begin
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl reset", q, CTRL_RESET);
        apb(1'b1, 8'hFC, 32'h0000FFFF);
        apb(1'b0, 8'hFC, 32'h0);
        chk("unmapped read", q, 32'h0);
        chk("no slave error", pslverr, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h00000001);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl readback", q, 32'h00000001);
        for (int i = 0; i < 11; i++) apb(1'b1, ca[i], cd[i]);
        done("registers");
        @(posedge clock);
        run_cmd <= 1'b1;
        target_in <= 16'sh1388;
        wt(3);
        chk("ramp not immediate", ramp_target == 16'sh1388, 32'h0);
        @(posedge clock);
        soft_bypass_in <= 1'b1;
        wt(5);
        chk("ramp bypassed", ramp_target, 32'h00001388);
        done("target ramp");
        @(posedge clock);
        p_term <= 16'sh4E20;
        apb(1'b1, ADDR_OLIM, 32'h00000BB8);
        wt(10);
        chk("output limit", speed_ref, 32'h00000BB8);
        apb(1'b0, ADDR_OUT, 32'h0);
        chk("output readback", q, 32'h00000BB8);
        @(posedge clock);
        p_term <= 16'sh0000;
        apb(1'b1, ADDR_OLIM, 32'h00002710);
        apb(1'b1, ADDR_OFFS, 32'h00000001);
        wt(10);
        chk("offset", speed_ref, 32'h0000000A);
        @(posedge clock);
        p_term <= 16'sh07D0;
        apb(1'b1, ADDR_OFFS, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h00000003);
        apb(1'b1, ADDR_GAIN, 32'h00000004);
        wt(10);
        chk("half gain", speed_ref, 32'h000003E8);
        @(posedge clock);
        freq_set <= 16'sh01F4;
        wt(10);
        chk("compensation", speed_ref, 32'h000005DC);
        apb(1'b1, ADDR_GAIN, 32'h00000008);
        apb(1'b1, ADDR_CTRL, 32'h00000001);
        @(posedge clock);
        p_term <= 16'sh03E8;
        wt(10);
        chk("reference mode", speed_ref, 32'h000003E8);
        @(posedge clock);
        d_err <= 16'sh0064;
        d_fb <= 16'sh012C;
        apb(1'b1, ADDR_CTRL, 32'h00000002);
        wt(10);
        chk("derivative on feedback", speed_ref, 32'h00000514);
        apb(1'b1, ADDR_CTRL, 32'h00000001);
        wt(10);
        chk("derivative on error", speed_ref, 32'h0000044C);
        @(posedge clock);
        d_err <= 16'sh0000;
        d_fb <= 16'sh0000;
        apb(1'b1, ADDR_FILT, 32'h00000032);
        @(posedge clock);
        p_term <= 16'sh07D0;
        wt(3);
        chk("filter slows", speed_ref == 16'sh07D0, 32'h0);
        apb(1'b1, ADDR_FILT, 32'h0);
        @(posedge clock);
        p_term <= 16'sh03E8;
        apb(1'b1, ADDR_CTRL, 32'h00000019);
        wt(300);
        chk("inverted reverse", reverse_cmd, 32'h1);
        chk("inverted speed", speed_ref, 32'h000003E8);
        apb(1'b1, ADDR_CTRL, 32'h00000039);
        wt(10);
        chk("prohibit speed", speed_ref, 32'h0);
        chk("prohibit reverse", reverse_cmd, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h00000001);
        @(posedge clock);
        p_term <= -16'sh03E8;
        wt(10);
        chk("no reverse select", reverse_cmd, 32'h0);
        done("output path");
        @(posedge clock);
        p_term <= 16'sh0000;
        hold_in <= 1'b1;
        i_increment <= 16'sh000A;
        wt(100);
        chk("integral hold", speed_ref, 32'h0);
        @(posedge clock);
        hold_in <= 1'b0;
        wt(400);
        chk("integral limit", speed_ref, 32'h000001F4);
        @(posedge clock);
        clk_en <= 1'b0;
        i_increment <= 16'sh0000;
        disable_in <= 1'b1;
        freq_set <= 16'sh04D2;
        wt(10);
        chk("frozen output", speed_ref, 32'h000001F4);
        @(posedge clock);
        clk_en <= 1'b1;
        wt(10);
        chk("regulator disabled", speed_ref, 32'h000004D2);
        done("integral");
        @(posedge clock);
        disable_in <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h00000041);
        repeat (3) begin
            @(posedge clock);
            feedback_in <= 16'sh0032;
            wt(8);
            @(posedge clock);
            feedback_in <= 16'sh03E8;
            wt(2);
        end
        chk("loss timer restart", alarm, 32'h0);
        @(posedge clock);
        feedback_in <= 16'sh0032;
        wt(60);
        chk("loss alarm", alarm, 32'h1);
        chk("alarm keeps running", run_out, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h00000081);
        wt(60);
        chk("loss fault", fault_out, 32'h1);
        chk("fault stops", run_out, 32'h0);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("fault status", q[ST_FAULT_BIT], 32'h1);
        chk("irq masked", irq, 32'h0);
        apb(1'b1, ADDR_MASK, 32'h0000000F);
        wt(2);
        chk("irq raised", irq, 32'h1);
        @(posedge clock);
        run_cmd <= 1'b0;
        feedback_in <= 16'sh03E8;
        apb(1'b1, ADDR_CTRL, 32'h00000001);
        apb(1'b1, ADDR_STAT, 32'h0000000F);
        @(posedge clock);
        run_cmd <= 1'b1;
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("status cleared", q[ST_FAULT_BIT], 32'h0);
        chk("fault released", fault_out, 32'h0);
        done("feedback loss");
        apb(1'b1, ADDR_SLVL, 32'h000001F4);
        @(posedge clock);
        target_in <= 16'sh0064;
        wt(60);
        chk("sleep entry", run_out, 32'h0);
        @(posedge clock);
        target_in <= 16'sh03E8;
        wt(60);
        chk("wake", run_out, 32'h1);
        @(posedge clock);
        disable_in <= 1'b1;
        target_in <= 16'sh0064;
        wt(60);
        chk("no sleep when disabled", run_out, 32'h1);
        done("sleep");
        end_sim();
    end
endmodule
`default_nettype wire
